// ### rtl/ipt_pkg.sv
// Constants and types for the host controller of the packet register target port.
package ipt_pkg;

    // Timing.
    localparam int IPT_SYS_CLK_HZ = 20000000;
    localparam int IPT_SCL_HZ = 100000;
    localparam logic [7:0] IPT_HALF_CYC = 8'(IPT_SYS_CLK_HZ / (2 * IPT_SCL_HZ));
    localparam int IPT_STRETCH_LIMIT_MS = 5;
    localparam int IPT_STRETCH_LIMIT_CYC = IPT_SYS_CLK_HZ / 1000 * IPT_STRETCH_LIMIT_MS;

    // Addressing and encodings.
    localparam logic [6:0] IPT_DEFAULT_TARGET = 7'h01;
    localparam logic IPT_DIR_WRITE = 1'b0;
    localparam logic IPT_DIR_READ = 1'b1;
    localparam logic [1:0] IPT_LEN_16 = 2'h0;
    localparam logic [1:0] IPT_LEN_32 = 2'h1;
    localparam logic [1:0] IPT_LEN_64 = 2'h2;
    localparam logic [1:0] IPT_LEN_RSV = 2'h3;
    localparam logic [3:0] IPT_BYTES_16 = 4'h2;
    localparam logic [3:0] IPT_BYTES_32 = 4'h4;
    localparam logic [3:0] IPT_BYTES_64 = 4'h8;
    localparam logic [3:0] IPT_ACK_BIT = 4'h8;
    localparam logic [2:0] IPT_CW_LAST = 3'h2;
    localparam logic [2:0] IPT_ZERO3 = 3'h0;

    // CRC-8, polynomial x^8 + x^2 + x + 1.
    localparam logic [7:0] IPT_CRC_POLY = 8'h07;
    localparam logic [7:0] IPT_CRC_INIT = 8'hFF;

    // Control word, bit 23 down to bit 0.
    typedef struct packed {
        logic operation_direction_bit;
        logic crc_en;
        logic [1:0] payload_length_field;
        logic [3:0] location_section_field;
        logic [3:0] page;
        logic [11:0] offset;
    } ipt_cw_t;

    typedef struct packed {
        logic busy;
        logic done;
        logic nack;
        logic crc_err;
        logic stretch_timeout;
        logic bad_length;
    } ipt_status_t;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_START_A,
        ST_START_R,
        ST_START_B,
        ST_BIT_LOW,
        ST_BIT_HIGH,
        ST_STOP_A,
        ST_STOP_B,
        ST_STOP_C
    } ipt_state_e;

    typedef enum logic [2:0] {
        PH_ADDR_W,
        PH_CW,
        PH_WDATA,
        PH_WCRC,
        PH_ADDR_R,
        PH_RDATA,
        PH_RCRC
    } ipt_phase_e;

    typedef struct packed {
        ipt_state_e st;
        ipt_phase_e ph;
        logic [7:0] tick;
        logic [19:0] stretch;
        logic [3:0] bit_cnt;
        logic [2:0] cnt;
        logic [7:0] sh;
        logic [7:0] crc;
        ipt_cw_t cw;
        logic [3:0] nbytes;
        logic [6:0] taddr;
        logic [63:0] wdata;
        logic [63:0] rdata;
        logic scl_s1;
        logic scl_s2;
        logic sda_s1;
        logic sda_s2;
        logic scl_oe_n;
        logic sda_oe_n;
        ipt_status_t status;
    } ipt_regs_t;

endpackage

// ### rtl/ipt_host.sv
// Bus controller that issues register packets to the target port over SCL and SDA.
//
// Overview of operation
// - First byte is 7-bit address plus direction.
// - Every packet opens with a write address.
// - Control word field layout, operation bit 23.
// - Length code selects 2, 4 or 8 bytes.
// - Section and page should be zero; the controller does not check them and sends them from cw_i as given.
// - Controller appends CRC after write data.
// - Payload bytes travel least significant first.
// - Read: restart, address with direction one.
// - Controller acknowledges every returned byte.
// - Read CRC byte read and acknowledged.
// - Every packet ends with stop, except one abandoned on a stretch timeout.
// - CRC-8 polynomial 0x07, initial 0xFF.
`timescale 1ns/1ps
`default_nettype none

module ipt_host
    import ipt_pkg::*;
#(
    parameter int STRETCH_CYC = IPT_STRETCH_LIMIT_CYC
)
(
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // User command port.
    input wire logic req_i,
    input wire logic [6:0] bus_target_address_i,
    input wire ipt_cw_t cw_i,
    input wire logic [63:0] wdata_i,
    output logic [63:0] rdata_o,
    output ipt_status_t status_o,
    // Open-drain bus pins; an enable low pulls the line low.
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o
);

    localparam logic [19:0] STRETCH_LIM = 20'(STRETCH_CYC);

    ipt_regs_t q;
    ipt_regs_t next_q;

    // CRC-8 over one byte, most significant bit first.
    function automatic logic [7:0] crc8_byte(input logic [7:0] crc_in, input logic [7:0] data);
        logic [7:0] c;
        c = crc_in ^ data;
        for (int i = 0; i < 8; i++)
        begin
            c = c[7] ? ((c << 1) ^ IPT_CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    logic half_done;
    logic rx_phase;
    logic [7:0] byte_crc;
    logic [2:0] cnt_inc;
    logic [3:0] cnt_next;

    assign half_done = (q.tick == IPT_HALF_CYC - 8'h01);
    assign rx_phase = (q.ph == PH_RDATA) || (q.ph == PH_RCRC);
    assign byte_crc = crc8_byte(q.crc, q.sh);
    assign cnt_inc = q.cnt + 3'h1;
    // The byte count needs a fourth bit, because the three-bit counter wraps to zero after the eighth byte.
    assign cnt_next = {1'b0, q.cnt} + 4'h1;

    always_comb
    begin
        next_q = q;
        next_q.status.done = 1'b0;
        next_q.scl_s1 = scl_i;
        next_q.scl_s2 = q.scl_s1;
        next_q.sda_s1 = sda_i;
        next_q.sda_s2 = q.sda_s1;
        next_q.tick = q.tick + 8'h01;
        case (q.st)
            ST_IDLE:
            begin
                next_q.scl_oe_n = 1'b1;
                next_q.sda_oe_n = 1'b1;
                next_q.tick = 8'h00;
                next_q.stretch = 20'h00000;
                if (req_i)
                begin
                    next_q.status = '0;
                    next_q.rdata = '0;
                    if (cw_i.payload_length_field == IPT_LEN_RSV)
                    begin
                        // The reserved length is refused before any bus activity.
                        next_q.status.bad_length = 1'b1;
                        next_q.status.done = 1'b1;
                    end
                    else
                    begin
                        next_q.cw = cw_i;
                        next_q.taddr = bus_target_address_i;
                        next_q.wdata = wdata_i;
                        case (cw_i.payload_length_field)
                            IPT_LEN_16: next_q.nbytes = IPT_BYTES_16;
                            IPT_LEN_32: next_q.nbytes = IPT_BYTES_32;
                            default: next_q.nbytes = IPT_BYTES_64;
                        endcase
                        next_q.sh = {bus_target_address_i, IPT_DIR_WRITE};
                        next_q.ph = PH_ADDR_W;
                        next_q.bit_cnt = 4'h0;
                        next_q.cnt = IPT_ZERO3;
                        next_q.crc = IPT_CRC_INIT;
                        next_q.status.busy = 1'b1;
                        next_q.st = ST_START_R;
                    end
                end
            end
            ST_START_A:
            begin
                // Repeated start: release SDA while SCL is still low.
                next_q.scl_oe_n = 1'b0;
                if (!q.scl_oe_n)
                begin
                    next_q.sda_oe_n = 1'b1;
                end
                if (half_done)
                begin
                    next_q.tick = 8'h00;
                    next_q.st = ST_START_R;
                end
            end
            ST_START_B:
            begin
                next_q.sda_oe_n = 1'b0;
                if (half_done)
                begin
                    next_q.tick = 8'h00;
                    next_q.st = ST_BIT_LOW;
                end
            end
            ST_BIT_LOW:
            begin
                next_q.scl_oe_n = 1'b0;
                // SDA moves only once SCL is already low, so a data change is never taken for start or stop.
                if (!q.scl_oe_n && q.bit_cnt == IPT_ACK_BIT)
                begin
                    next_q.sda_oe_n = !rx_phase;
                end
                else if (!q.scl_oe_n)
                begin
                    next_q.sda_oe_n = rx_phase | q.sh[7];
                end
                if (half_done)
                begin
                    next_q.tick = 8'h00;
                    next_q.st = ST_BIT_HIGH;
                end
            end
            ST_START_R, ST_BIT_HIGH, ST_STOP_B:
            begin
                next_q.scl_oe_n = 1'b1;
                if (!q.scl_s2)
                begin
                    // The target is stretching; the half period starts once SCL is seen high.
                    next_q.tick = 8'h00;
                    next_q.stretch = q.stretch + 20'h00001;
                    if (q.stretch >= STRETCH_LIM)
                    begin
                        next_q.scl_oe_n = 1'b1;
                        next_q.sda_oe_n = 1'b1;
                        next_q.status.stretch_timeout = 1'b1;
                        next_q.status.busy = 1'b0;
                        next_q.status.done = 1'b1;
                        next_q.st = ST_IDLE;
                    end
                end
                else
                begin
                    next_q.stretch = 20'h00000;
                    if (half_done)
                    begin
                        next_q.tick = 8'h00;
                        case (q.st)
                            ST_START_R: next_q.st = ST_START_B;
                            ST_STOP_B: next_q.st = ST_STOP_C;
                            default: next_q.st = ST_BIT_LOW;
                        endcase
                        if (q.st == ST_BIT_HIGH && q.bit_cnt != IPT_ACK_BIT)
                        begin
                            // Sampling our own bits too leaves the byte on the wire in sh.
                            next_q.sh = {q.sh[6:0], q.sda_s2};
                            next_q.bit_cnt = q.bit_cnt + 4'h1;
                        end
                        else if (q.st == ST_BIT_HIGH)
                        begin
                            next_q.bit_cnt = 4'h0;
                            if (!rx_phase && q.sda_s2)
                            begin
                                next_q.status.nack = 1'b1;
                                next_q.st = ST_STOP_A;
                            end
                            else
                            begin
                                if (q.ph != PH_WCRC && q.ph != PH_RCRC)
                                begin
                                    next_q.crc = byte_crc;
                                end
                                case (q.ph)
                                    PH_ADDR_W:
                                    begin
                                        next_q.ph = PH_CW;
                                        next_q.cnt = IPT_ZERO3;
                                        next_q.sh = q.cw[23:16];
                                    end
                                    PH_CW:
                                    begin
                                        next_q.cnt = cnt_inc;
                                        next_q.sh = (q.cnt == IPT_ZERO3) ? q.cw[15:8] : q.cw[7:0];
                                        if (q.cnt == IPT_CW_LAST)
                                        begin
                                            next_q.cnt = IPT_ZERO3;
                                            if (q.cw.operation_direction_bit == IPT_DIR_READ)
                                            begin
                                                next_q.ph = PH_ADDR_R;
                                                next_q.sh = {q.taddr, IPT_DIR_READ};
                                                next_q.st = ST_START_A;
                                            end
                                            else
                                            begin
                                                next_q.ph = PH_WDATA;
                                                next_q.sh = q.wdata[7:0];
                                            end
                                        end
                                    end
                                    PH_WDATA:
                                    begin
                                        // Exactly nbytes go out, so the target never sees a count mismatch.
                                        next_q.cnt = cnt_inc;
                                        next_q.sh = q.wdata[{cnt_inc, IPT_ZERO3} +: 8];
                                        if (cnt_next == q.nbytes)
                                        begin
                                            if (q.cw.crc_en)
                                            begin
                                                next_q.ph = PH_WCRC;
                                                next_q.sh = byte_crc;
                                            end
                                            else
                                            begin
                                                next_q.st = ST_STOP_A;
                                            end
                                        end
                                    end
                                    PH_WCRC:
                                    begin
                                        next_q.st = ST_STOP_A;
                                    end
                                    PH_ADDR_R:
                                    begin
                                        next_q.ph = PH_RDATA;
                                        next_q.sh = 8'hFF;
                                    end
                                    PH_RDATA:
                                    begin
                                        next_q.rdata[{q.cnt, IPT_ZERO3} +: 8] = q.sh;
                                        next_q.cnt = cnt_inc;
                                        if (cnt_next == q.nbytes)
                                        begin
                                            if (q.cw.crc_en)
                                            begin
                                                next_q.ph = PH_RCRC;
                                            end
                                            else
                                            begin
                                                next_q.st = ST_STOP_A;
                                            end
                                        end
                                    end
                                    PH_RCRC:
                                    begin
                                        next_q.status.crc_err = (q.sh != q.crc);
                                        next_q.st = ST_STOP_A;
                                    end
                                    default:
                                    begin
                                        next_q.st = ST_STOP_A;
                                    end
                                endcase
                            end
                        end
                    end
                end
            end
            ST_STOP_A:
            begin
                next_q.scl_oe_n = 1'b0;
                if (!q.scl_oe_n)
                begin
                    next_q.sda_oe_n = 1'b0;
                end
                if (half_done)
                begin
                    next_q.tick = 8'h00;
                    next_q.st = ST_STOP_B;
                end
            end
            ST_STOP_C:
            begin
                next_q.sda_oe_n = 1'b1;
                if (half_done)
                begin
                    next_q.tick = 8'h00;
                    next_q.status.busy = 1'b0;
                    next_q.status.done = 1'b1;
                    next_q.st = ST_IDLE;
                end
            end
            default:
            begin
                next_q.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            q <= '0;
            q.st <= ST_IDLE;
            q.ph <= PH_ADDR_W;
            q.crc <= IPT_CRC_INIT;
            q.taddr <= IPT_DEFAULT_TARGET;
            q.scl_s1 <= 1'b1;
            q.scl_s2 <= 1'b1;
            q.sda_s1 <= 1'b1;
            q.sda_s2 <= 1'b1;
            q.scl_oe_n <= 1'b1;
            q.sda_oe_n <= 1'b1;
        end
        else
        begin
            q <= next_q;
        end
    end

    assign rdata_o = q.rdata;
    assign status_o = q.status;
    assign scl_oe_n_o = q.scl_oe_n;
    assign sda_oe_n_o = q.sda_oe_n;
    // The data level is always low; only the enables decide whether the line is pulled.
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;

endmodule

`default_nettype wire

// ### tb/ipt_host_assertions.sv
// Concurrent checks on the ports of the packet bus controller.
`timescale 1ns/1ps
`default_nettype none
module ipt_host_assertions
    import ipt_pkg::*;
#(
    parameter int STRETCH_CYC = 300
)
(
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // User side.
    input wire logic req_i,
    input wire logic [6:0] bus_target_address_i,
    input wire ipt_cw_t cw_i,
    input wire logic [63:0] wdata_i,
    input wire logic [63:0] rdata_o,
    input wire ipt_status_t status_o,
    // Bus pins.
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe_n_o,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n_o
);
    logic [19:0] low_cnt;
    logic take;
    assign take = req_i && !status_o.busy;
    // Counts how long the clock line stays low after the controller has let it go.
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
        if (!arst_n_i)
            low_cnt <= 20'h0;
        else if (status_o.busy && scl_oe_n_o && !scl_i)
            low_cnt <= low_cnt + 20'h1;
        else
            low_cnt <= 20'h0;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    property p_bad_len;
        take && cw_i.payload_length_field == IPT_LEN_RSV |=> status_o.done && status_o.bad_length && !status_o.busy;
    endproperty
    a_bad_len: assert property (p_bad_len) else $error("reserved length not refused");
    property p_busy;
        take && cw_i.payload_length_field != IPT_LEN_RSV |=> status_o.busy && !status_o.done;
    endproperty
    a_busy: assert property (p_busy) else $error("packet not started");
    property p_flags_clr;
        take |=> !status_o.nack && !status_o.crc_err && !status_o.stretch_timeout;
    endproperty
    a_flags_clr: assert property (p_flags_clr) else $error("stale error flag");
    property p_rdata_clr;
        take |=> rdata_o == 64'h0;
    endproperty
    a_rdata_clr: assert property (p_rdata_clr) else $error("read data not cleared");
    property p_start;
        $rose(status_o.busy) && scl_i |-> ##[1:300] ($fell(sda_oe_n_o) && scl_i);
    endproperty
    a_start: assert property (p_start) else $error("no start condition");
    property p_idle;
        !status_o.busy |-> scl_oe_n_o && sda_oe_n_o;
    endproperty
    a_idle: assert property (p_idle) else $error("bus held while idle");
    property p_done_stop;
        status_o.done && !status_o.bad_length && !status_o.stretch_timeout
            |-> $past(scl_oe_n_o, 150) && !$past(sda_oe_n_o, 150) && $past(sda_oe_n_o, 50);
    endproperty
    a_done_stop: assert property (p_done_stop) else $error("packet ended without stop");
    property p_stretch;
        low_cnt <= 20'(STRETCH_CYC + 8);
    endproperty
    a_stretch: assert property (p_stretch) else $error("stretch wait unbounded");
endmodule
`default_nettype wire

// ### tb/ipt_target_model.sv
// Behavioural register target on the open-drain bus.
`timescale 1ns/1ps
`default_nettype none
module ipt_target_model #(
    parameter logic [6:0] OWN_ADDR = 7'h01
)
(
    // Bus lines, a pull output high pulls the line low.
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_pull_o,
    output logic sda_pull_o,
    // Faults commanded by the bench.
    input wire logic hold_scl_i,
    input wire logic bad_crc_i
);
    logic [31:0] mem [int];
    logic [7:0] rx [16];
    logic [7:0] crc = 8'hFF;
    logic [7:0] sh = 8'h00;
    logic [23:0] cw = 24'h0;
    logic tx = 1'b0;
    logic ign = 1'b1;
    logic crc_ok = 1'b0;
    logic txv = 1'b0;
    int bitn = -1;
    int k = 0;
    int need = 2;
    int txi = 0;
    int loc = 0;
    assign scl_pull_o = hold_scl_i;
    initial sda_pull_o = 1'b0;
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++)
            r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
        return r;
    endfunction
    task automatic rx_byte();
        rx[k] = sh;
        if (k == 0)
        begin
            ign = sh[7:1] != OWN_ADDR;
            tx = sh[0];
            txi = 0;
        end
        if (k == 3)
        begin
            cw = {rx[1], rx[2], rx[3]};
            need = 2 << cw[21:20];
            loc = int'(cw[19:0]);
        end
        if (k == 4 + need && cw[22])
            crc_ok = sh == crc;
        else
            crc = crc8(crc, sh);
        sda_pull_o = !ign;
        k++;
    endtask
    // A write lands only on stop, so a short or corrupt packet leaves memory untouched.
    task automatic commit();
        logic [31:0] w;
        if (!cw[23] && k == 4 + need + int'(cw[22]) && (crc_ok || !cw[22]))
            for (int h = 0; h < need; h += 4)
            begin
                w = 32'h0;
                for (int i = 0; i < 4 && h + i < need; i++)
                    w[8*i +: 8] = rx[4 + h + i];
                mem[loc + h / 2] = w;
            end
    endtask
    always @(negedge sda_i)
        if (scl_i === 1'b1)
        begin
            bitn = -1;
            k = 0;
            tx = 1'b0;
            ign = 1'b0;
        end
    always @(posedge sda_i)
        if (scl_i === 1'b1)
        begin
            if (!ign)
                commit();
            ign = 1'b1;
            crc = 8'hFF;
            crc_ok = 1'b0;
        end
    always @(posedge scl_i)
        if (!tx && bitn >= 0 && bitn < 8)
            sh = {sh[6:0], sda_i};
    always @(negedge scl_i)
        if (!ign)
        begin
            bitn = (bitn == 8) ? 0 : bitn + 1;
            if (tx)
            begin
                if (bitn == 0)
                begin
                    txv = txi < need + int'(cw[22]);
                    if (txi < need)
                        sh = 8'(mem[loc + 2 * (txi / 4)] >> (8 * (txi % 4)));
                    else
                        sh = crc ^ {7'h0, bad_crc_i};
                    if (txi < need)
                        crc = crc8(crc, sh);
                    txi++;
                end
                sda_pull_o = txv && bitn < 8 && !sh[7 - bitn];
            end
            else if (bitn == 8)
                rx_byte();
            else
                sda_pull_o = 1'b0;
        end
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the packet bus controller against a behavioural target.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import ipt_pkg::*;
;
    localparam int STRETCH = 300;
    logic clk_sys_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic req, hold, bad_crc, scl_o, scl_oe_n, sda_o, sda_oe_n, m_scl, m_sda;
    logic [6:0] taddr;
    ipt_cw_t cw;
    logic [63:0] wdata, rdata;
    ipt_status_t status;
    wire logic scl, sda;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    assign scl = (scl_oe_n | scl_o) & ~m_scl;
    assign sda = (sda_oe_n | sda_o) & ~m_sda;
    always #25 clk_sys_i = ~clk_sys_i;
    ipt_host #(.STRETCH_CYC(STRETCH)) ipt_host_inst (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
        .req_i(req), .bus_target_address_i(taddr), .cw_i(cw), .wdata_i(wdata), .rdata_o(rdata),
        .status_o(status), .scl_i(scl), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_n_o(sda_oe_n));
    ipt_target_model ipt_target_model_inst (.scl_i(scl), .sda_i(sda), .scl_pull_o(m_scl),
        .sda_pull_o(m_sda), .hold_scl_i(hold), .bad_crc_i(bad_crc));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic ipt_cw_t mk(input logic op, input logic ce, input logic [1:0] len, input logic [11:0] off);
        return '{op, ce, len, 4'h0, 4'h0, off};
    endfunction
    task automatic pkt(input string nm, input logic [6:0] a, input ipt_cw_t c, input logic [63:0] d);
        int n;
        @(posedge clk_sys_i);
        #1;
        taddr = a;
        cw = c;
        wdata = d;
        req = 1'b1;
        @(posedge clk_sys_i);
        #1;
        req = 1'b0;
        n = 0;
        while (status.done !== 1'b1 && n < 40000)
        begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        // A packet that never finishes counts as a mismatch.
        if (status.done !== 1'b1)
            num_errors++;
        $display("test %s finished", nm);
    endtask
    always @(posedge clk_sys_i)
    begin
        cyc++;
        // The packets below need about 69000 cycles in all.
        if (cyc == 90000)
        begin
            num_errors++;
            end_sim();
        end
    end
    initial
    begin
        req = 1'b0;
        hold = 1'b0;
        bad_crc = 1'b0;
        taddr = IPT_DEFAULT_TARGET;
        cw = '0;
        wdata = 64'h0;
        repeat (10) @(posedge clk_sys_i);
        #1;
        arst_n_i = 1'b1;
        chk({status, scl_oe_n, sda_oe_n}, 8'h03);
        pkt("write64 crc", IPT_DEFAULT_TARGET, mk(IPT_DIR_WRITE, 1'b1, IPT_LEN_64, 12'h080), 64'h0123456789ABCDEF);
        chk(status, 6'h10);
        chk(ipt_target_model_inst.mem[32'h80], 32'h89ABCDEF);
        chk(ipt_target_model_inst.mem[32'h82], 32'h01234567);
        pkt("read64 crc", IPT_DEFAULT_TARGET, mk(IPT_DIR_READ, 1'b1, IPT_LEN_64, 12'h080), 64'h0);
        chk(rdata, 64'h0123456789ABCDEF);
        chk(status, 6'h10);
        bad_crc = 1'b1;
        pkt("read16 bad crc", IPT_DEFAULT_TARGET, mk(IPT_DIR_READ, 1'b1, IPT_LEN_16, 12'h082), 64'h0);
        bad_crc = 1'b0;
        chk(rdata, 64'h4567);
        chk(status, 6'h14);
        pkt("reserved length", IPT_DEFAULT_TARGET, mk(IPT_DIR_WRITE, 1'b0, IPT_LEN_RSV, 12'h080), 64'h0);
        chk(status, 6'h11);
        chk(rdata, 64'h0);
        pkt("wrong target", 7'h02, mk(IPT_DIR_WRITE, 1'b0, IPT_LEN_16, 12'h080), 64'h0);
        chk(status, 6'h18);
        hold = 1'b1;
        pkt("stretch", IPT_DEFAULT_TARGET, mk(IPT_DIR_WRITE, 1'b0, IPT_LEN_16, 12'h080), 64'h0);
        chk({status, scl_oe_n, sda_oe_n}, 8'h4B);
        hold = 1'b0;
        end_sim();
    end
endmodule
bind ipt_host ipt_host_assertions #(.STRETCH_CYC(STRETCH_CYC)) ipt_host_assertions_inst (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .req_i(req_i), .bus_target_address_i(bus_target_address_i),
    .cw_i(cw_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .status_o(status_o), .scl_i(scl_i), .scl_o(scl_o),
    .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o));
`default_nettype wire
